// File: design/txbd_defs.svh
// Purpose: offsets, field positions and reset values of the tx descriptor block
// Assumes: each register is one 32-bit word at byte address 4 * index
// Notes:   definitions only
`ifndef TXBD_DEFS_SVH
`define TXBD_DEFS_SVH

// register indexes, byte address is four times the index
`define TXBD_IDX_PB0      8'hb0
`define TXBD_IDX_PB1      8'hb1
`define TXBD_IDX_PB2      8'hb2
`define TXBD_IDX_SB0      8'hb4
`define TXBD_IDX_SB1      8'hb5
`define TXBD_IDX_SB2      8'hb6
`define TXBD_IDX_PC0      8'hb8
`define TXBD_IDX_PC1      8'hb9
`define TXBD_IDX_SC0      8'hba
`define TXBD_IDX_SC1      8'hbb
`define TXBD_IDX_CTRL     8'hf0
`define TXBD_IDX_STAT     8'hf1

// reset value of every byte register
`define TXBD_RST_BYTE     8'h00

// count high register: command bits and writable mask
`define TXBD_BIT_ME       7
`define TXBD_BIT_FR       6
`define TXBD_BIT_IF       5
`define TXBD_HI_MASK      8'hef
`define TXBD_CMD_CLR      8'he0
`define TXBD_FULL_MASK    8'hff

// control register fields
`define TXBD_CTL_EN       0
`define TXBD_CTL_SW       1
`define TXBD_CTL_MASK     8'h03

// bus responses
`define TXBD_RESP_OK      2'h0
`define TXBD_RESP_ERR     2'h2

`endif

// File: design/txbd_pkg.sv
// Purpose: shared types of the tx descriptor block
// Assumes: nothing beyond the defs header
// Notes:   slot order is the storage order of the byte registers
package txbd_pkg;

   // storage slot of each byte register
   typedef enum logic [3:0] {
      SL_PB0, SL_PB1, SL_PB2, SL_SB0, SL_SB1, SL_SB2,
      SL_PC0, SL_PC1, SL_SC0, SL_SC1, SL_CTRL, SL_NONE
   } txbd_slot_t;

   // engine states
   typedef enum logic [2:0] {S_IDLE, S_LOAD, S_FETCH, S_SEND, S_FINISH} txbd_state_t;

   // one buffer descriptor as the engine sees it
   typedef struct packed {
      logic [23:0] base;
      logic [11:0] len;
      logic [2:0]  cmd;   // message end, frame, info frame
   } txbd_desc_t;

   // register write issued by the bus slave
   typedef struct packed {
      logic       go;
      logic [7:0] idx;
      logic [7:0] data;
      logic       strb0;
   } txbd_wreq_t;

endpackage : txbd_pkg

// File: design/txbd_byte_reg.sv
// Purpose: one byte register with write mask and hardware clear
// Assumes: synchronous active-low reset
// Notes:   a software write in the clear cycle wins
`timescale 1ns/1ps
`default_nettype none
module txbd_byte_reg #(
   parameter logic [7:0] MASK = 8'hff  // writable bits, others read zero
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       we,
   input  wire logic [7:0] wd,
   input  wire logic [7:0] clr,
   output var  logic [7:0] q
);
   // store, or drop the bits hardware has consumed
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         q <= 8'h00;
      else if (we)
         q <= wd & MASK;
      else
         q <= q & ~clr;
   end
endmodule : txbd_byte_reg
`default_nettype wire

// File: design/txbd_axil_slave.sv
// Purpose: axi4-lite slave front end of the descriptor registers
// Assumes: one write and one read in flight at most
// Notes:   address and data may arrive in either order
`timescale 1ns/1ps
`default_nettype none
`include "txbd_defs.svh"
module txbd_axil_slave
   import txbd_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [9:0]       awaddr,
   input  wire logic             awvalid,
   output var  logic             awready,
   input  wire logic [31:0]      wdata,
   input  wire logic [3:0]       wstrb,
   input  wire logic             wvalid,
   output var  logic             wready,
   output var  logic [1:0]       bresp,
   output var  logic             bvalid,
   input  wire logic             bready,
   input  wire logic [9:0]       araddr,
   input  wire logic             arvalid,
   output var  logic             arready,
   output var  logic [31:0]      rdata,
   output var  logic [1:0]       rresp,
   output var  logic             rvalid,
   input  wire logic             rready,
   output var txbd_wreq_t        wreq,
   input  wire logic             wr_ok,
   output var  logic [7:0]       rd_idx,
   input  wire logic [7:0]       rd_data,
   input  wire logic             rd_ok
);
   logic [7:0] aw_idx_q;  // held write index
   logic [7:0] w_data_q;  // held write byte
   logic       w_strb_q;  // low lane enabled
   logic       aw_h_q;    // address taken
   logic       w_h_q;     // data taken

   // write fires once both halves are held
   always_comb
   begin
      wreq.go    = aw_h_q && w_h_q && !bvalid;
      wreq.idx   = aw_idx_q;
      wreq.data  = w_data_q;
      wreq.strb0 = w_strb_q;
      rd_idx     = araddr[9:2];
   end

   // write channels, ready drops while a half is held
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         aw_h_q <= 1'b0; w_h_q <= 1'b0; awready <= 1'b1; wready <= 1'b1;
         bvalid <= 1'b0; bresp <= `TXBD_RESP_OK;
         aw_idx_q <= 8'h00; w_data_q <= 8'h00; w_strb_q <= 1'b0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_h_q <= 1'b1; awready <= 1'b0; aw_idx_q <= awaddr[9:2];
         end
         if (wvalid && wready)
         begin
            w_h_q <= 1'b1; wready <= 1'b0; w_data_q <= wdata[7:0]; w_strb_q <= wstrb[0];
         end
         if (wreq.go)
         begin
            bvalid <= 1'b1; bresp <= wr_ok ? `TXBD_RESP_OK : `TXBD_RESP_ERR;
            aw_h_q <= 1'b0; w_h_q <= 1'b0;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0; awready <= 1'b1; wready <= 1'b1;
         end
      end
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         arready <= 1'b1; rvalid <= 1'b0; rdata <= 32'h0000_0000; rresp <= `TXBD_RESP_OK;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0; rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_ok ? rd_data : 8'h00};
         rresp <= rd_ok ? `TXBD_RESP_OK : `TXBD_RESP_ERR;
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0; arready <= 1'b1;
      end
   end
endmodule : txbd_axil_slave
`default_nettype wire

// File: design/txbd_top.sv
// Purpose: transmit dma buffer descriptors and the engine that walks them
// Assumes: memory and transmit path run on MCLK; one byte per memory read
// Notes:   command bits in a count high register arm that buffer
//
// Behaviour
// - primary base is 24-bit, three bytes
// - single mode fetches only from primary buffer
// - switched mode alternates primary and secondary buffers
// - secondary base used only in switched mode
// - secondary base is 24-bit, three bytes
// - primary count 12 bits, split low/high
// - single mode ignores secondary count
// - count high bit7 is message end command
// - count high bit6 is frame command
// - bit5 info frame command, bit4 reads zero
// - secondary count high has same layout
// - secondary count 12 bits, switched mode only
`timescale 1ns/1ps
`default_nettype none
`include "txbd_defs.svh"
module txbd_top
   import txbd_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic [9:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output var  logic        S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output var  logic        S_AXI_WREADY,
   output var  logic [1:0]  S_AXI_BRESP,
   output var  logic        S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [9:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output var  logic        S_AXI_ARREADY,
   output var  logic [31:0] S_AXI_RDATA,
   output var  logic [1:0]  S_AXI_RRESP,
   output var  logic        S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   output var  logic        MEM_REQ,
   output var  logic [23:0] MEM_ADDR,
   input  wire logic        MEM_ACK,
   input  wire logic [7:0]  MEM_RDATA,
   output var  logic        TX_VALID,
   output var  logic [7:0]  TX_DATA,
   input  wire logic        TX_READY,
   output var  logic        TX_MSG_END,
   output var  logic        TX_FRAME,
   output var  logic        TX_INFO_FRAME
);
   localparam int NSLOT = int'(SL_NONE);  // number of byte registers

   txbd_wreq_t  wreq;                 // write from the bus slave
   logic        wr_ok;                // write index is mapped
   logic [7:0]  rd_idx;               // read index from the bus slave
   logic [7:0]  rd_data;              // read byte
   logic        rd_ok;                // read index is mapped
   txbd_slot_t  wr_slot;              // decoded write slot
   txbd_slot_t  rd_slot;              // decoded read slot
   logic [7:0]  reg_q [0:NSLOT-1];    // register storage
   logic [7:0]  clr   [0:NSLOT-1];    // hardware clear per register
   txbd_desc_t  desc  [0:1];          // primary and secondary descriptor
   txbd_desc_t  cur_desc;             // descriptor in work
   logic [1:0]  pend;                 // buffer armed by a command bit
   logic        dma_en;               // internal dma mode active
   logic        sw_mode;              // switched-buffer operation
   logic        go;                   // engine may start from idle
   logic        sel;                  // buffer picked at start
   logic        next_other;           // continue with the other buffer
   txbd_state_t state_q;              // engine state
   logic        cur_buf_q;            // buffer in work, 1 is secondary
   logic        last_buf_q;           // last buffer completed
   logic [11:0] offset_q;             // bytes already passed on
   logic [7:0]  status;               // status register image

   // index to storage slot, unknown indexes give none
   function automatic txbd_slot_t slot_of(input logic [7:0] idx);
      case (idx)
         `TXBD_IDX_PB0:  slot_of = SL_PB0;
         `TXBD_IDX_PB1:  slot_of = SL_PB1;
         `TXBD_IDX_PB2:  slot_of = SL_PB2;
         `TXBD_IDX_SB0:  slot_of = SL_SB0;
         `TXBD_IDX_SB1:  slot_of = SL_SB1;
         `TXBD_IDX_SB2:  slot_of = SL_SB2;
         `TXBD_IDX_PC0:  slot_of = SL_PC0;
         `TXBD_IDX_PC1:  slot_of = SL_PC1;
         `TXBD_IDX_SC0:  slot_of = SL_SC0;
         `TXBD_IDX_SC1:  slot_of = SL_SC1;
         `TXBD_IDX_CTRL: slot_of = SL_CTRL;
         default:        slot_of = SL_NONE;
      endcase
   endfunction : slot_of

   // bus front end
   txbd_axil_slave u_bus (
      .clk     (MCLK),
      .rst_n   (RST_N),
      .awaddr  (S_AXI_AWADDR),
      .awvalid (S_AXI_AWVALID),
      .awready (S_AXI_AWREADY),
      .wdata   (S_AXI_WDATA),
      .wstrb   (S_AXI_WSTRB),
      .wvalid  (S_AXI_WVALID),
      .wready  (S_AXI_WREADY),
      .bresp   (S_AXI_BRESP),
      .bvalid  (S_AXI_BVALID),
      .bready  (S_AXI_BREADY),
      .araddr  (S_AXI_ARADDR),
      .arvalid (S_AXI_ARVALID),
      .arready (S_AXI_ARREADY),
      .rdata   (S_AXI_RDATA),
      .rresp   (S_AXI_RRESP),
      .rvalid  (S_AXI_RVALID),
      .rready  (S_AXI_RREADY),
      .wreq    (wreq),
      .wr_ok   (wr_ok),
      .rd_idx  (rd_idx),
      .rd_data (rd_data),
      .rd_ok   (rd_ok)
   );

   // address decode; the status register takes no writes
   always_comb
   begin
      wr_slot = slot_of(wreq.idx);
      rd_slot = slot_of(rd_idx);
      wr_ok   = (wr_slot != SL_NONE);
      rd_ok   = (rd_slot != SL_NONE) || (rd_idx == `TXBD_IDX_STAT);
      rd_data = (rd_slot != SL_NONE) ? reg_q[rd_slot] : status;
   end

   // one byte register per slot; count high bit4 and spare control bits stay zero
   for (genvar i = 0; i < NSLOT; i++)
   begin : g_reg
      localparam logic [7:0] MASK =
         (i == int'(SL_PC1) || i == int'(SL_SC1)) ? `TXBD_HI_MASK :
         (i == int'(SL_CTRL)) ? `TXBD_CTL_MASK : `TXBD_FULL_MASK;
      txbd_byte_reg #(.MASK(MASK)) u_reg (
         .clk   (MCLK),
         .rst_n (RST_N),
         .we    (wreq.go && wreq.strb0 && (int'(wr_slot) == i)),
         .wd    (wreq.data),
         .clr   (clr[i]),
         .q     (reg_q[i])
      );
   end

   // command bits of the finished buffer are consumed at the end of it
   always_comb
   begin
      for (int j = 0; j < NSLOT; j++)
         clr[j] = 8'h00;
      if (state_q == S_FINISH)
         clr[cur_buf_q ? SL_SC1 : SL_PC1] = `TXBD_CMD_CLR;
   end

   // descriptors assembled from the byte registers
   always_comb
   begin
      desc[0].base = {reg_q[SL_PB2], reg_q[SL_PB1], reg_q[SL_PB0]};
      desc[1].base = {reg_q[SL_SB2], reg_q[SL_SB1], reg_q[SL_SB0]};
      desc[0].len  = {reg_q[SL_PC1][3:0], reg_q[SL_PC0]};
      desc[1].len  = {reg_q[SL_SC1][3:0], reg_q[SL_SC0]};
      desc[0].cmd  = reg_q[SL_PC1][`TXBD_BIT_ME:`TXBD_BIT_IF];
      desc[1].cmd  = reg_q[SL_SC1][`TXBD_BIT_ME:`TXBD_BIT_IF];
      cur_desc     = desc[cur_buf_q];
      pend[0]      = |desc[0].cmd;
      pend[1]      = |desc[1].cmd;
      dma_en       = reg_q[SL_CTRL][`TXBD_CTL_EN];
      sw_mode      = reg_q[SL_CTRL][`TXBD_CTL_SW];
      status       = {5'h00, last_buf_q, cur_buf_q, state_q != S_IDLE};
   end

   // buffer choice: single mode never looks at the secondary descriptor
   always_comb
   begin
      if (!sw_mode)
      begin
         sel = 1'b0;
         go  = dma_en && pend[0];
      end
      else
      begin
         sel = pend[!last_buf_q] ? !last_buf_q : last_buf_q;
         go  = dma_en && (|pend);
      end
      next_other = dma_en && sw_mode && pend[!cur_buf_q];
   end

   // engine sequencing; a mode change takes effect between buffers only
   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         state_q <= S_IDLE; cur_buf_q <= 1'b0; last_buf_q <= 1'b1; offset_q <= 12'h000;
      end
      else
      begin
         case (state_q)
            S_IDLE:
               if (go)
               begin
                  cur_buf_q <= sel; offset_q <= 12'h000; state_q <= S_LOAD;
               end
            S_LOAD:
               // a zero count sends nothing but still issues its commands
               state_q <= (offset_q == cur_desc.len) ? S_FINISH : S_FETCH;
            S_FETCH:
               if (MEM_ACK)
                  state_q <= S_SEND;
            S_SEND:
               if (TX_READY)
               begin
                  offset_q <= offset_q + 12'h001;
                  state_q  <= S_LOAD;
               end
            // command bits are dropped here; a software write landing now wins,
            // so a buffer re-armed at its very end is simply sent again
            S_FINISH:
            begin
               last_buf_q <= cur_buf_q;
               offset_q   <= 12'h000;
               if (next_other)
               begin
                  cur_buf_q <= !cur_buf_q;
                  state_q   <= S_LOAD;
               end
               else
                  state_q <= S_IDLE;
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end

   // memory read request, held until acknowledged
   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         MEM_REQ <= 1'b0; MEM_ADDR <= 24'h00_0000;
      end
      else if (state_q == S_LOAD && offset_q != cur_desc.len)
      begin
         MEM_REQ  <= 1'b1;
         MEM_ADDR <= cur_desc.base + {12'h000, offset_q};
      end
      else if (state_q == S_FETCH && MEM_ACK)
         MEM_REQ <= 1'b0;
   end

   // fetched byte toward the transmit path
   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         TX_VALID <= 1'b0; TX_DATA <= 8'h00;
      end
      else if (state_q == S_FETCH && MEM_ACK)
      begin
         TX_VALID <= 1'b1; TX_DATA <= MEM_RDATA;
      end
      else if (TX_READY)
         TX_VALID <= 1'b0;
   end

   // command pulses after the last byte of the buffer has been passed on
   always_ff @(posedge MCLK)
   begin
      if (!RST_N)
      begin
         TX_MSG_END <= 1'b0; TX_FRAME <= 1'b0; TX_INFO_FRAME <= 1'b0;
      end
      else
      begin
         TX_MSG_END    <= (state_q == S_FINISH) && cur_desc.cmd[2];
         TX_FRAME      <= (state_q == S_FINISH) && cur_desc.cmd[1];
         TX_INFO_FRAME <= (state_q == S_FINISH) && cur_desc.cmd[0];
      end
   end

   // checks
   a_single_primary: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_q == S_IDLE && go && !sw_mode) |=> (state_q == S_LOAD && !cur_buf_q))
      else $error("single mode started the secondary buffer");
   a_sec_switched_only: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_q == S_FINISH && !sw_mode) |=> (state_q == S_IDLE))
      else $error("a second buffer followed outside switched mode");
   a_first_addr_base: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_q == S_LOAD && offset_q == 12'h000 && cur_desc.len != 12'h000)
      |=> (MEM_REQ && MEM_ADDR == $past(cur_desc.base)))
      else $error("first fetch not at buffer base");
   a_req_held: assert property (@(posedge MCLK) disable iff (!RST_N)
      (MEM_REQ && !MEM_ACK) |=> (MEM_REQ && $stable(MEM_ADDR)))
      else $error("memory request dropped before acknowledge");
   a_byte_forward: assert property (@(posedge MCLK) disable iff (!RST_N)
      (MEM_REQ && MEM_ACK) |=> (TX_VALID && TX_DATA == $past(MEM_RDATA) && !MEM_REQ))
      else $error("fetched byte not offered to transmit path");
   a_tx_held: assert property (@(posedge MCLK) disable iff (!RST_N)
      (TX_VALID && !TX_READY) |=> (TX_VALID && $stable(TX_DATA)))
      else $error("transmit byte changed before it was taken");
   a_len_reached: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_q == S_FINISH) |-> (offset_q == cur_desc.len))
      else $error("buffer closed before its byte count");
   a_cmd_msg_end: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_q == S_FINISH) |=> (TX_MSG_END == $past(cur_desc.cmd[2])))
      else $error("message end pulse does not follow command bit");
   a_cmd_frame: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_q == S_FINISH) |=> (TX_FRAME == $past(cur_desc.cmd[1])))
      else $error("frame pulse does not follow command bit");
   a_cmd_info: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_q == S_FINISH) |=> (TX_INFO_FRAME == $past(cur_desc.cmd[0])))
      else $error("info frame pulse does not follow command bit");
   a_bit4_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
      (reg_q[SL_PC1][4] == 1'b0) && (reg_q[SL_SC1][4] == 1'b0))
      else $error("count high bit four is not zero");
   a_alternate: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_q == S_FINISH && next_other)
      |=> (cur_buf_q != $past(cur_buf_q) && state_q == S_LOAD))
      else $error("switched mode did not alternate buffers");
   a_sec_len_used: assert property (@(posedge MCLK) disable iff (!RST_N)
      (state_q == S_FINISH && cur_buf_q) |-> (offset_q == desc[1].len))
      else $error("secondary buffer length not honoured");

   c_single_run: cover property (@(posedge MCLK) disable iff (!RST_N)
      state_q == S_FINISH && !sw_mode && TX_VALID == 1'b0);
   c_switch_run: cover property (@(posedge MCLK) disable iff (!RST_N)
      state_q == S_FINISH && next_other);
   c_stall_tx: cover property (@(posedge MCLK) disable iff (!RST_N)
      (TX_VALID && !TX_READY) ##1 (TX_VALID && TX_READY));
   c_sec_start: cover property (@(posedge MCLK) disable iff (!RST_N)
      state_q == S_LOAD && cur_buf_q && offset_q == 12'h000);
   c_sec_armed_single: cover property (@(posedge MCLK) disable iff (!RST_N)
      state_q == S_FINISH && !sw_mode && pend[1]);
endmodule : txbd_top
`default_nettype wire

// File: dv/txbd_mem_model.sv
// Purpose: memory and transmit sink beside the descriptor engine
// Assumes: one byte per read, same clock
// Notes:   slow mode delays ack and stalls the sink
`timescale 1ns/1ps
`default_nettype none
module txbd_mem_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic [23:0] mem_addr,
   output var  logic        mem_ack,
   output var  logic [7:0]  mem_rdata,
   output var  logic        tx_ready
);
   logic [1:0] wait_q;  // ack delay count
   // one read answered, data derived from its address
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mem_ack   <= 1'b0;
         mem_rdata <= 8'h00;
         wait_q    <= 2'h0;
      end
      else if (mem_req && !mem_ack && wait_q == (slow ? 2'h2 : 2'h0))
      begin
         mem_ack   <= 1'b1;
         mem_rdata <= mem_addr[7:0] ^ mem_addr[15:8] ^ mem_addr[23:16] ^ 8'h5a;
         wait_q    <= 2'h0;
      end
      else
      begin
         mem_ack   <= 1'b0;
         mem_rdata <= ~mem_rdata;  // no stale byte outside the ack cycle
         wait_q    <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      end
   end
   // sink stalls every other cycle when slow
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         tx_ready <= 1'b1;
      else
         tx_ready <= slow ? ~tx_ready : 1'b1;
   end
endmodule : txbd_mem_model
`default_nettype wire

// File: dv/test_txbd_top.sv
// Purpose: self-checking bench of the tx descriptor block
// Assumes: register byte address is four times its index
// Notes:   a monitor checks every transmitted byte against a queue
`timescale 1ns/1ps
`default_nettype none
`include "txbd_defs.svh"
module test_txbd_top;
   logic        MCLK, RST_N, awv, wv, bre, arv, rre, slow;
   logic [9:0]  awa, ara;
   logic [31:0] wd;
   logic [3:0]  ws;
   wire  logic  awr, wrd, bv, arr, rv, mreq, mack, txv, txr, me, fr, inf;
   wire  logic [1:0]  br, rr;
   wire  logic [31:0] rd;
   wire  logic [23:0] madr;
   wire  logic [7:0]  mrd, txd;
   int          err_total, n_tests, n_me, n_fr, n_if;
   logic [23:0] exp_q[$];  // addresses still to be sent
   logic [7:0]  regs[10] = '{`TXBD_IDX_PB0, `TXBD_IDX_PB1, `TXBD_IDX_PB2, `TXBD_IDX_SB0,
      `TXBD_IDX_SB1, `TXBD_IDX_SB2, `TXBD_IDX_PC0, `TXBD_IDX_PC1, `TXBD_IDX_SC0, `TXBD_IDX_SC1};

   txbd_top u_txbd_top (.MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
      .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
      .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
      .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd),
      .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .MEM_REQ(mreq),
      .MEM_ADDR(madr), .MEM_ACK(mack), .MEM_RDATA(mrd), .TX_VALID(txv), .TX_DATA(txd),
      .TX_READY(txr), .TX_MSG_END(me), .TX_FRAME(fr), .TX_INFO_FRAME(inf));
   txbd_mem_model u_txbd_mem_model (.clk(MCLK), .rst_n(RST_N), .slow(slow), .mem_req(mreq),
      .mem_addr(madr), .mem_ack(mack), .mem_rdata(mrd), .tx_ready(txr));

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("[FAIL] %s expected %h seen %h", s, e, g);
         err_total++;
      end
   endtask : chk

   // one write, both halves offered together
   task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er);
      int n;
      @(posedge MCLK);
      awa <= {ix, 2'b00};
      wd  <= {24'h0, d};
      awv <= 1'b1;
      wv  <= 1'b1;
      bre <= 1'b1;
      for (n = 0; n < 100 && !bv; n++)
      begin
         @(posedge MCLK);
         if (awv && awr) awv <= 1'b0;
         if (wv && wrd) wv <= 1'b0;
      end
      bre <= 1'b0;
      chk("bresp", {30'h0, er}, bv ? {30'h0, br} : 32'hx);
   endtask : wr

   // one read, rready held until data is seen
   task automatic rdc(input logic [7:0] ix, input logic [7:0] e, input logic [1:0] er);
      int n;
      @(posedge MCLK);
      ara <= {ix, 2'b00};
      arv <= 1'b1;
      rre <= 1'b1;
      for (n = 0; n < 100 && !rv; n++)
      begin
         @(posedge MCLK);
         if (arv && arr) arv <= 1'b0;
      end
      rre <= 1'b0;
      chk("rdata", {22'h0, er, e}, rv ? {22'h0, rr, rd[7:0]} : 32'hx);
   endtask : rdc

   // wait until queue drained and pulses seen, then linger for strays
   task automatic wait_done(input int tgt);
      for (int n = 0; n < 8000 && (exp_q.size() != 0 || n_me + n_fr + n_if < tgt); n++)
         @(posedge MCLK);
      repeat (40) @(posedge MCLK);
      chk("queue left", 0, exp_q.size());
   endtask : wait_done

   // reset values, writable bits, unmapped and read-only places
   task automatic t_regs();
      foreach (regs[i])
      begin
         rdc(regs[i], 8'h00, `TXBD_RESP_OK);
         wr(regs[i], 8'hfe, `TXBD_RESP_OK);
         rdc(regs[i], (i == 7 || i == 9) ? 8'hee : 8'hfe, `TXBD_RESP_OK);
         wr(regs[i], 8'h00, `TXBD_RESP_OK);
      end
      wr(8'h20, 8'h55, `TXBD_RESP_ERR);
      rdc(8'h20, 8'h00, `TXBD_RESP_ERR);
      wr(`TXBD_IDX_STAT, 8'h55, `TXBD_RESP_ERR);
      rdc(`TXBD_IDX_STAT, 8'h04, `TXBD_RESP_OK);
      ws <= 4'h0;
      wr(`TXBD_IDX_PB0, 8'h54, `TXBD_RESP_OK);
      ws <= 4'h1;
      rdc(`TXBD_IDX_PB0, 8'h00, `TXBD_RESP_OK);
   endtask : t_regs

   // switched mode: primary then secondary, pulses per buffer
   task automatic t_switched();
      exp_q = '{24'h200, 24'h201, 24'h300, 24'h301};
      wr(`TXBD_IDX_PB1, 8'h02, `TXBD_RESP_OK);
      wr(`TXBD_IDX_PC0, 8'h02, `TXBD_RESP_OK);
      wr(`TXBD_IDX_PC1, 8'h80, `TXBD_RESP_OK);
      wr(`TXBD_IDX_SB1, 8'h03, `TXBD_RESP_OK);
      wr(`TXBD_IDX_SC0, 8'h02, `TXBD_RESP_OK);
      wr(`TXBD_IDX_SC1, 8'h20, `TXBD_RESP_OK);
      wr(`TXBD_IDX_CTRL, 8'h03, `TXBD_RESP_OK);
      wait_done(2);
      chk("pulses", 32'h101, {n_me[3:0], n_fr[3:0], n_if[3:0]});
      rdc(`TXBD_IDX_PC1, 8'h00, `TXBD_RESP_OK);
      rdc(`TXBD_IDX_STAT, 8'h06, `TXBD_RESP_OK);
   endtask : t_switched

   // single mode, 257 bytes, secondary armed yet never used
   task automatic t_single();
      slow <= 1'b1;
      for (int a = 24'h100; a <= 24'h200; a++) exp_q.push_back(a[23:0]);
      wr(`TXBD_IDX_CTRL, 8'h01, `TXBD_RESP_OK);
      wr(`TXBD_IDX_SB1, 8'h04, `TXBD_RESP_OK);
      wr(`TXBD_IDX_SC1, 8'he0, `TXBD_RESP_OK);
      wr(`TXBD_IDX_PB1, 8'h01, `TXBD_RESP_OK);
      wr(`TXBD_IDX_PC0, 8'h01, `TXBD_RESP_OK);
      wr(`TXBD_IDX_PC1, 8'h41, `TXBD_RESP_OK);
      wait_done(3);
      chk("pulses", 32'h111, {n_me[3:0], n_fr[3:0], n_if[3:0]});
      rdc(`TXBD_IDX_PC1, 8'h01, `TXBD_RESP_OK);
      rdc(`TXBD_IDX_SC1, 8'he0, `TXBD_RESP_OK);
   endtask : t_single

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   // each sent byte must be the next address's data
   always @(posedge MCLK)
   begin
      if (txv && txr)
         chk("tx byte", exp_q.size() ? {24'h0, madr_pat(exp_q.pop_front())} : 32'hx, txd);
      if (me) n_me++;
      if (fr) n_fr++;
      if (inf) n_if++;
   end

   function automatic logic [7:0] madr_pat(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5a;
   endfunction : madr_pat

   initial
   begin
      MCLK = 1'b0;
      forever #12.5 MCLK = ~MCLK;
   end

   initial
   begin
      repeat (30000) @(posedge MCLK);
      err_total++;
      report_and_stop();
   end

   initial
   begin
      {RST_N, awv, wv, bre, arv, rre, slow, awa, ara, wd} = '0;
      ws = 4'h1;
      repeat (12) @(posedge MCLK);
      RST_N <= 1'b1;
      t_regs();
      t_switched();
      t_single();
      report_and_stop();
   end
endmodule : test_txbd_top
`default_nettype wire
